// file: ptes_pkg.sv
// constants for the precision-time target reload and event status block
// assumes a 100 MHz pclk and a 32-bit APB slave port
`default_nettype none
package ptes_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_RELOAD_SELECT    = 12'h100;
  localparam logic [11:0] OFF_STATUS           = 12'h108;
  localparam logic [11:0] OFF_ENABLE           = 12'h10C;
  localparam logic [11:0] OFF_TARGET_SEC_A     = 12'h120;
  localparam logic [11:0] OFF_TARGET_NS_A      = 12'h124;
  localparam logic [11:0] OFF_RELOAD_SEC_A     = 12'h128;
  localparam logic [11:0] OFF_RELOAD_NS_A      = 12'h12C;
  localparam logic [11:0] OFF_CHAN_STRIDE      = 12'h010;
  localparam logic [11:0] OFF_CAPTURE_INFO     = 12'h140;
  localparam logic [11:0] OFF_MANUAL_CAPTURE   = 12'h144;
  localparam logic [11:0] OFF_TIMER_CLEAR_CTL  = 12'h148;
  localparam logic [11:0] OFF_TOP_STATUS       = 12'h150;
  localparam logic [11:0] OFF_TOP_ENABLE       = 12'h154;
  // ----------------------------------------------------------------
  // status and enable field layout
  // ----------------------------------------------------------------
  localparam int          FALL_LSB             = 24;
  localparam int          RISE_LSB             = 16;
  localparam int          EGRESS_BIT           = 12;
  localparam int          INGRESS_BIT          = 8;
  localparam int          TIMER_B_BIT          = 1;
  localparam int          TIMER_A_BIT          = 0;
  localparam logic [31:0] STATUS_DEFINED_MASK  = 32'hFFFF_1103;
  localparam logic [31:0] STATUS_RESET         = 32'h0000_0000;
  localparam logic [1:0]  SELECT_RESET         = 2'h0;
  // capture information layout, egress count low, ingress count above
  localparam int          EGRESS_CNT_LSB       = 0;
  localparam int          INGRESS_CNT_LSB      = 4;
  localparam logic [2:0]  STAMP_DEPTH          = 3'h4;
  // timer clear control: enable bit and 3-bit capture input select
  localparam int          CLR_A_SEL_LSB        = 0;
  localparam int          CLR_A_EN_BIT         = 3;
  localparam int          CLR_B_SEL_LSB        = 4;
  localparam int          CLR_B_EN_BIT         = 7;
  // ----------------------------------------------------------------
  // time arithmetic and pulse qualification
  // ----------------------------------------------------------------
  localparam logic [29:0] NS_PER_SEC           = 30'h3B9A_CA00;
  localparam int          CLK_PERIOD_NS        = 10;
  localparam int          CAPTURE_MIN_NS       = 40;
  localparam int          CAPTURE_MIN_CYC      = (CAPTURE_MIN_NS + CLK_PERIOD_NS - 1)
                                                 / CLK_PERIOD_NS;
  localparam logic [2:0]  CAPTURE_RUN_LAST     = 3'(CAPTURE_MIN_CYC);
  localparam int          CAPTURE_INPUTS       = 8;
endpackage
`default_nettype wire

// file: ptes_capture_qualify.sv
// one capture input: pulse-width qualification and edge pulses
// assumes the input is already synchronous to pclk
`default_nettype none
module ptes_capture_qualify (
  input  wire  logic pclk,
  input  wire  logic presetn,
  input  wire  logic level_in,
  output logic       rise_pulse,
  output logic       fall_pulse
);
  // ----------------------------------------------------------------
  // run-length filter
  // ----------------------------------------------------------------
  logic       stable_reg, stable_next;
  logic [2:0] run_reg, run_next;
  logic       rise_reg, rise_next;
  logic       fall_reg, fall_next;

  always_comb begin
    stable_next = stable_reg;
    run_next    = 3'h0;
    rise_next   = 1'b0;
    fall_next   = 1'b0;
    if (level_in != stable_reg) begin
      // new level must persist longer than the minimum
      if (run_reg == ptes_pkg::CAPTURE_RUN_LAST) begin
        stable_next = level_in;
        rise_next   = level_in;
        fall_next   = ~level_in;
      end else begin
        run_next = run_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_reg <= 1'b0;
      run_reg    <= 3'h0;
      rise_reg   <= 1'b0;
      fall_reg   <= 1'b0;
    end else begin
      stable_reg <= stable_next;
      run_reg    <= run_next;
      rise_reg   <= rise_next;
      fall_reg   <= fall_next;
    end
  end

  assign rise_pulse = rise_reg;
  assign fall_pulse = fall_reg;
endmodule
`default_nettype wire

// file: ptes_top.sv
// target reload/add policy, timestamp event status and summary event
// assumes an APB master on pclk and pulse inputs synchronous to pclk
//
// Register access over APB was left to the implementer.
`default_nettype none
module ptes_top (
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [11:0] paddr,
  input  wire  logic [31:0] pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire  logic [1:0]  compare_event,
  input  wire  logic [7:0]  capture_in,
  input  wire  logic        egress_stored,
  input  wire  logic        egress_popped,
  input  wire  logic        ingress_stored,
  input  wire  logic        ingress_popped,
  output logic [31:0]       target_sec_a,
  output logic [29:0]       target_ns_a,
  output logic [31:0]       target_sec_b,
  output logic [29:0]       target_ns_b,
  output logic              irq
);
  // ----------------------------------------------------------------
  // capture qualification
  // ----------------------------------------------------------------
  logic [7:0] cap_rise;
  logic [7:0] cap_fall;

  genvar gi;
  generate
    for (gi = 0; gi < ptes_pkg::CAPTURE_INPUTS; gi++) begin : g_cap
      ptes_capture_qualify u_q (
        .pclk       (pclk),
        .presetn    (presetn),
        .level_in   (capture_in[gi]),
        .rise_pulse (cap_rise[gi]),
        .fall_pulse (cap_fall[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0]  select_reg, select_next;
  logic [31:0] status_reg, status_next;
  logic [31:0] enable_reg, enable_next;
  logic [31:0] tsec_reg [2], tsec_next [2];
  logic [29:0] tns_reg [2], tns_next [2];
  logic [31:0] rsec_reg [2], rsec_next [2];
  logic [29:0] rns_reg [2], rns_next [2];
  logic [2:0]  egress_cnt_reg, egress_cnt_next;
  logic [2:0]  ingress_cnt_reg, ingress_cnt_next;
  logic [7:0]  clr_ctl_reg, clr_ctl_next;
  logic        top_en_reg, top_en_next;
  logic        summary_reg, summary_next;
  logic        irq_reg, irq_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;

  logic        wr_en;
  logic        rd_en;
  logic [31:0] status_set;
  logic [31:0] status_clr;
  logic [7:0]  manual_cap;
  logic [30:0] ns_sum;
  logic [1:0]  timer_clr;
  logic        hit;
  logic [31:0] rd_val;

  // channel register decode, shared by read and write
  function automatic logic chan_hit(input logic [11:0] a, input logic [11:0] base,
                                    input int ch);
    chan_hit = (a == base + 12'(ch) * ptes_pkg::OFF_CHAN_STRIDE);
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    wr_en            = psel && penable && pready_reg && pwrite;
    rd_en            = psel && penable && !pready_reg && !pwrite;
    select_next      = select_reg;
    enable_next      = enable_reg;
    clr_ctl_next     = clr_ctl_reg;
    top_en_next      = top_en_reg;
    egress_cnt_next  = egress_cnt_reg;
    ingress_cnt_next = ingress_cnt_reg;
    manual_cap       = 8'h00;
    ns_sum           = 31'h0;
    rd_val           = 32'h0000_0000;
    hit              = 1'b0;
    for (int c = 0; c < 2; c++) begin
      tsec_next[c] = tsec_reg[c];
      tns_next[c]  = tns_reg[c];
      rsec_next[c] = rsec_reg[c];
      rns_next[c]  = rns_reg[c];
    end
    // register writes
    if (wr_en) begin
      if (paddr == ptes_pkg::OFF_RELOAD_SELECT) select_next = pwdata[1:0];
      if (paddr == ptes_pkg::OFF_ENABLE)
        enable_next = pwdata & ptes_pkg::STATUS_DEFINED_MASK;
      if (paddr == ptes_pkg::OFF_TIMER_CLEAR_CTL) clr_ctl_next = pwdata[7:0];
      if (paddr == ptes_pkg::OFF_TOP_ENABLE) top_en_next = pwdata[0];
      if (paddr == ptes_pkg::OFF_MANUAL_CAPTURE) manual_cap = pwdata[7:0];
      for (int c = 0; c < 2; c++) begin
        if (chan_hit(paddr, ptes_pkg::OFF_TARGET_SEC_A, c)) tsec_next[c] = pwdata;
        if (chan_hit(paddr, ptes_pkg::OFF_TARGET_NS_A, c)) tns_next[c] = pwdata[29:0];
        if (chan_hit(paddr, ptes_pkg::OFF_RELOAD_SEC_A, c)) rsec_next[c] = pwdata;
        if (chan_hit(paddr, ptes_pkg::OFF_RELOAD_NS_A, c)) rns_next[c] = pwdata[29:0];
      end
    end
    // compare events update targets
    for (int c = 0; c < 2; c++) begin
      if (compare_event[c]) begin
        if (select_reg[c]) begin
          tsec_next[c] = rsec_reg[c];
          tns_next[c]  = rns_reg[c];
        end else begin
          ns_sum = {1'b0, tns_reg[c]} + {1'b0, rns_reg[c]};
          if (ns_sum >= {1'b0, ptes_pkg::NS_PER_SEC}) begin
            ns_sum       = ns_sum - {1'b0, ptes_pkg::NS_PER_SEC};
            tsec_next[c] = tsec_reg[c] + rsec_reg[c] + 32'h1;
          end else begin
            tsec_next[c] = tsec_reg[c] + rsec_reg[c];
          end
          tns_next[c] = ns_sum[29:0];
        end
      end
    end
    // stamp counts, saturating at the buffer depth
    if (egress_stored && !egress_popped && egress_cnt_reg != ptes_pkg::STAMP_DEPTH)
      egress_cnt_next = egress_cnt_reg + 3'h1;
    else if (egress_popped && !egress_stored && egress_cnt_reg != 3'h0)
      egress_cnt_next = egress_cnt_reg - 3'h1;
    if (ingress_stored && !ingress_popped && ingress_cnt_reg != ptes_pkg::STAMP_DEPTH)
      ingress_cnt_next = ingress_cnt_reg + 3'h1;
    else if (ingress_popped && !ingress_stored && ingress_cnt_reg != 3'h0)
      ingress_cnt_next = ingress_cnt_reg - 3'h1;
    // status sources
    status_set = 32'h0000_0000;
    status_set[ptes_pkg::FALL_LSB +: 8] = cap_fall | manual_cap;
    status_set[ptes_pkg::RISE_LSB +: 8] = cap_rise | manual_cap;
    status_set[ptes_pkg::EGRESS_BIT]    = egress_stored;
    status_set[ptes_pkg::INGRESS_BIT]   = ingress_stored;
    status_set[ptes_pkg::TIMER_A_BIT]   = compare_event[0];
    status_set[ptes_pkg::TIMER_B_BIT]   = compare_event[1];
    timer_clr[0] = clr_ctl_reg[ptes_pkg::CLR_A_EN_BIT]
                   && cap_rise[clr_ctl_reg[ptes_pkg::CLR_A_SEL_LSB +: 3]];
    timer_clr[1] = clr_ctl_reg[ptes_pkg::CLR_B_EN_BIT]
                   && cap_rise[clr_ctl_reg[ptes_pkg::CLR_B_SEL_LSB +: 3]];
    status_clr = 32'h0000_0000;
    if (wr_en && paddr == ptes_pkg::OFF_STATUS) status_clr = pwdata;
    status_clr[ptes_pkg::TIMER_A_BIT] = status_clr[ptes_pkg::TIMER_A_BIT] | timer_clr[0];
    status_clr[ptes_pkg::TIMER_B_BIT] = status_clr[ptes_pkg::TIMER_B_BIT] | timer_clr[1];
    // set wins over clear; enables play no part here
    status_next = ((status_reg & ~status_clr) | status_set)
                  & ptes_pkg::STATUS_DEFINED_MASK;
    summary_next = |(status_next & enable_next);
    irq_next     = summary_next && top_en_next;
    // read mux
    case (paddr)
      ptes_pkg::OFF_RELOAD_SELECT:   begin rd_val = {30'h0, select_reg}; hit = 1'b1; end
      ptes_pkg::OFF_STATUS:          begin rd_val = status_reg; hit = 1'b1; end
      ptes_pkg::OFF_ENABLE:          begin rd_val = enable_reg; hit = 1'b1; end
      ptes_pkg::OFF_TIMER_CLEAR_CTL: begin rd_val = {24'h0, clr_ctl_reg}; hit = 1'b1; end
      ptes_pkg::OFF_TOP_STATUS:      begin rd_val = {31'h0, summary_reg}; hit = 1'b1; end
      ptes_pkg::OFF_TOP_ENABLE:      begin rd_val = {31'h0, top_en_reg}; hit = 1'b1; end
      ptes_pkg::OFF_MANUAL_CAPTURE:  begin rd_val = 32'h0000_0000; hit = 1'b1; end
      ptes_pkg::OFF_CAPTURE_INFO: begin
        rd_val[ptes_pkg::EGRESS_CNT_LSB +: 3]  = egress_cnt_reg;
        rd_val[ptes_pkg::INGRESS_CNT_LSB +: 3] = ingress_cnt_reg;
        hit = 1'b1;
      end
      default: begin
        for (int c = 0; c < 2; c++) begin
          if (chan_hit(paddr, ptes_pkg::OFF_TARGET_SEC_A, c)) begin
            rd_val = tsec_reg[c];
            hit    = 1'b1;
          end
          if (chan_hit(paddr, ptes_pkg::OFF_TARGET_NS_A, c)) begin
            rd_val = {2'h0, tns_reg[c]};
            hit    = 1'b1;
          end
          if (chan_hit(paddr, ptes_pkg::OFF_RELOAD_SEC_A, c)) begin
            rd_val = rsec_reg[c];
            hit    = 1'b1;
          end
          if (chan_hit(paddr, ptes_pkg::OFF_RELOAD_NS_A, c)) begin
            rd_val = {2'h0, rns_reg[c]};
            hit    = 1'b1;
          end
        end
      end
    endcase
    // one wait state, answer registered
    pready_next  = psel && penable && !pready_reg;
    pslverr_next = psel && penable && !pready_reg && !hit;
    prdata_next  = rd_en ? rd_val : prdata_reg;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_reg      <= ptes_pkg::SELECT_RESET;
      status_reg      <= ptes_pkg::STATUS_RESET;
      enable_reg      <= 32'h0000_0000;
      clr_ctl_reg     <= 8'h00;
      top_en_reg      <= 1'b0;
      egress_cnt_reg  <= 3'h0;
      ingress_cnt_reg <= 3'h0;
      summary_reg     <= 1'b0;
      irq_reg         <= 1'b0;
      prdata_reg      <= 32'h0000_0000;
      pready_reg      <= 1'b0;
      pslverr_reg     <= 1'b0;
      for (int c = 0; c < 2; c++) begin
        tsec_reg[c] <= 32'h0000_0000;
        tns_reg[c]  <= 30'h0;
        rsec_reg[c] <= 32'h0000_0000;
        rns_reg[c]  <= 30'h0;
      end
    end else begin
      select_reg      <= select_next;
      status_reg      <= status_next;
      enable_reg      <= enable_next;
      clr_ctl_reg     <= clr_ctl_next;
      top_en_reg      <= top_en_next;
      egress_cnt_reg  <= egress_cnt_next;
      ingress_cnt_reg <= ingress_cnt_next;
      summary_reg     <= summary_next;
      irq_reg         <= irq_next;
      prdata_reg      <= prdata_next;
      pready_reg      <= pready_next;
      pslverr_reg     <= pslverr_next;
      for (int c = 0; c < 2; c++) begin
        tsec_reg[c] <= tsec_next[c];
        tns_reg[c]  <= tns_next[c];
        rsec_reg[c] <= rsec_next[c];
        rns_reg[c]  <= rns_next[c];
      end
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign irq          = irq_reg;
  assign target_sec_a = tsec_reg[0];
  assign target_ns_a  = tns_reg[0];
  assign target_sec_b = tsec_reg[1];
  assign target_ns_b  = tns_reg[1];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_reload_copy_a: assert property (compare_event[0] && select_reg[0] |=>
    tsec_reg[0] == $past(rsec_reg[0]) && tns_reg[0] == $past(rns_reg[0]))
    else $error("reload did not copy channel a");
  a_add_seconds_b: assert property (compare_event[1] && !select_reg[1] && !wr_en |=>
    tsec_reg[1] == $past(tsec_reg[1]) + $past(rsec_reg[1])
    + {31'h0, $past({1'b0, tns_reg[1]} + {1'b0, rns_reg[1]} >= {1'b0, ptes_pkg::NS_PER_SEC})})
    else $error("add did not advance channel b");
  a_w1c_clear: assert property (wr_en && paddr == ptes_pkg::OFF_STATUS
    && pwdata[ptes_pkg::EGRESS_BIT] && !egress_stored |=> !status_reg[ptes_pkg::EGRESS_BIT])
    else $error("write one did not clear");
  a_w0_keeps: assert property (wr_en && paddr == ptes_pkg::OFF_STATUS
    && !clr_ctl_reg[ptes_pkg::CLR_A_EN_BIT] && !clr_ctl_reg[ptes_pkg::CLR_B_EN_BIT] |=>
    ($past(status_reg) & ~$past(pwdata) & ~status_reg) == 32'h0000_0000)
    else $error("write zero cleared a bit");
  a_summary_or: assert property (##1 summary_reg == |(status_reg & enable_reg))
    else $error("summary differs from enabled status");
  a_set_no_enable: assert property (egress_stored |=> status_reg[ptes_pkg::EGRESS_BIT])
    else $error("status bit missed its source");
  a_irq_gate: assert property (irq |-> summary_reg && top_en_reg)
    else $error("interrupt without summary and enable");
  a_fall_capture: assert property (capture_in[2] [*5] ##1 !capture_in[2] [*5]
    |-> ##[1:2] status_reg[ptes_pkg::FALL_LSB + 2])
    else $error("qualified falling edge not captured");
  a_short_pulse: assert property (!capture_in[2] ##1 capture_in[2] [*4]
    ##1 !capture_in[2] |-> !cap_rise[2] ##1 !cap_rise[2])
    else $error("short pulse accepted");
  a_count_bound: assert property (egress_cnt_reg <= ptes_pkg::STAMP_DEPTH
    && ingress_cnt_reg <= ptes_pkg::STAMP_DEPTH)
    else $error("stamp count above depth");
  a_reserved_zero: assert property ((status_reg & ~ptes_pkg::STATUS_DEFINED_MASK) == 0)
    else $error("reserved status bit set");
  c_reload_event: cover property (compare_event[1] && select_reg[1]);
  c_irq_raised: cover property ($rose(irq));
  c_clear_race: cover property (wr_en && paddr == ptes_pkg::OFF_STATUS && egress_stored);
  c_count_full: cover property (egress_cnt_reg == ptes_pkg::STAMP_DEPTH);
endmodule
`default_nettype wire

// file: tb.sv
// testbench for ptes_top: apb register access, target update, event status
// assumes the ptes_pkg package and ptes_top compiled before this file
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, target_sec_a, target_sec_b;
  logic [29:0] target_ns_a, target_ns_b;
  logic [1:0]  compare_event;
  logic [7:0]  capture_in;
  logic        egress_stored, egress_popped, ingress_stored, ingress_popped;
  int          n_mismatch;
  int          checks;
  ptes_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compare_event(compare_event), .capture_in(capture_in),
    .egress_stored(egress_stored), .egress_popped(egress_popped),
    .ingress_stored(ingress_stored), .ingress_popped(ingress_popped),
    .target_sec_a(target_sec_a), .target_ns_a(target_ns_a), .target_sec_b(target_sec_b),
    .target_ns_b(target_ns_b), .irq(irq));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("pready wait", 32'h0000_0002, n);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(name, exp, r);
  endtask
  task automatic fire(input logic [1:0] m);
    compare_event <= m;
    @(posedge pclk);
    compare_event <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic hold_cap(input logic [7:0] v, input int cyc);
    capture_in <= v;
    repeat (cyc) @(posedge pclk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset_and_map();
    logic [31:0] r;
    logic        e;
    rd(12'h108, 32'h0000_0000, "status reset");
    rd(12'h100, 32'h0000_0000, "select reset");
    apb(1'b0, 12'h104, 32'h0, r, e);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", 32'h0000_0000, r);
    wr(12'h10C, 32'hFFFF_FFFF);
    rd(12'h10C, 32'hFFFF_1103, "enable layout");
    wr(12'h10C, 32'h0000_0000);
  endtask
  task automatic s_targets();
    wr(12'h128, 32'h0000_0011);
    wr(12'h12C, 32'h0000_0022);
    wr(12'h100, 32'h0000_0001);
    rd(12'h100, 32'h0000_0001, "select bits");
    fire(2'h1);
    chk("reload sec a", 32'h0000_0011, target_sec_a);
    chk("reload ns a", 32'h0000_0022, {2'h0, target_ns_a});
    rd(12'h108, 32'h0000_0001, "status a");
    wr(12'h130, 32'h0000_0005);
    wr(12'h134, 32'h3B9A_C9FB);
    wr(12'h138, 32'h0000_0001);
    wr(12'h13C, 32'h0000_000A);
    fire(2'h2);
    chk("add sec b", 32'h0000_0007, target_sec_b);
    chk("add ns b", 32'h0000_0005, {2'h0, target_ns_b});
    rd(12'h108, 32'h0000_0003, "status ab");
  endtask
  task automatic s_summary();
    wr(12'h10C, 32'h0000_0002);
    wr(12'h154, 32'h0000_0001);
    chk("irq both", 32'h1, {31'h0, irq});
    rd(12'h150, 32'h0000_0001, "summary");
    wr(12'h154, 32'h0000_0000);
    chk("irq top off", 32'h0, {31'h0, irq});
    wr(12'h154, 32'h0000_0001);
    wr(12'h10C, 32'h0000_0001);
    rd(12'h150, 32'h0000_0001, "summary a");
    wr(12'h10C, 32'h0000_0000);
    rd(12'h150, 32'h0000_0000, "summary off");
    rd(12'h108, 32'h0000_0003, "status kept");
    wr(12'h10C, 32'h0000_0002);
    wr(12'h108, 32'h0000_0002);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(12'h108, 32'h0000_EEFC);
    rd(12'h108, 32'h0000_0001, "w1c status");
  endtask
  task automatic s_capture();
    wr(12'h148, 32'h0000_00AA);
    rd(12'h148, 32'h0000_00AA, "clear ctl");
    fire(2'h2);
    hold_cap(8'h04, 4);
    hold_cap(8'h00, 8);
    rd(12'h108, 32'h0000_0003, "short pulse");
    hold_cap(8'h04, 6);
    hold_cap(8'h00, 10);
    rd(12'h108, 32'h0404_0000, "edges");
    chk("irq capture", 32'h0, {31'h0, irq});
    wr(12'h144, 32'h0000_0008);
    rd(12'h108, 32'h0C0C_0000, "manual");
  endtask
  task automatic s_stamps();
    egress_stored <= 1'b1;
    ingress_stored <= 1'b1;
    @(posedge pclk);
    ingress_stored <= 1'b0;
    repeat (4) @(posedge pclk);
    egress_stored <= 1'b0;
    @(posedge pclk);
    rd(12'h108, 32'h0C0C_1100, "stamp status");
    rd(12'h140, 32'h0000_0014, "stamp counts");
    egress_popped <= 1'b1;
    ingress_popped <= 1'b1;
    @(posedge pclk);
    egress_popped <= 1'b0;
    ingress_popped <= 1'b0;
    @(posedge pclk);
    rd(12'h140, 32'h0000_0003, "stamp pop");
    wr(12'h108, 32'hFFFF_FFFF);
    rd(12'h108, 32'h0000_0000, "clear all");
  endtask
  // ----------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    n_mismatch = 0;
    checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {compare_event, capture_in} = '0;
    {egress_stored, egress_popped, ingress_stored, ingress_popped} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_reset_and_map();
    s_targets();
    s_summary();
    s_capture();
    s_stamps();
    conclude();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
